// ---- plc_io_params.svh ----
// Register offsets, field positions, codes and reset values of the system I/O block
`ifndef PLC_IO_PARAMS_SVH
`define PLC_IO_PARAMS_SVH

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_CHAN_EN 8'h04
`define OFS_STATUS 8'h08
`define OFS_IRQ_STAT 8'h0c
`define OFS_IRQ_MASK 8'h10
`define OFS_CHAN_STAT 8'h14
`define OFS_VOLUME 8'h18
`define OFS_RATE 8'h1c

// Control register fields
`define CTRL_MODE_LSB 0
`define CTRL_MODE_W 3
`define CTRL_RDEF_LSB 4
`define CTRL_RDEF_W 2

// Operating mode codes
`define MODE_SETUP 3'h0
`define MODE_PRIME 3'h1
`define MODE_DISPENSE 3'h2
`define MODE_METER 3'h3
`define MODE_BUBBLE 3'h4

// Ready definition codes
`define RDEF_IDLE 2'h0
`define RDEF_IDLE_NOFAULT 2'h1
`define RDEF_ARMED 2'h2
`define RDEF_ARMED_FULL 2'h3

// Interrupt status bits
`define IRQ_TRIG 0
`define IRQ_LOAD 1
`define IRQ_LOCKOUT 2
`define IRQ_FAULT 3
`define IRQ_W 4

// Reset values: nothing survives power loss
`define RST_CTRL 32'h0000_0000
`define RST_WORD 32'h0000_0000
`define RST_IRQ 4'h0

`endif

// ---- plc_io_pkg.sv ----
// Types shared by the system I/O block
package plc_io_pkg;
  typedef enum logic [1:0] {LOAD_IDLE, LOAD_ARM, LOAD_RUN} load_state_t;
endpackage : plc_io_pkg

// ---- chan_bus_if.sv ----
// Bundle between the system I/O top and its channel gating logic
`timescale 1ns/1ns
interface chan_bus_if #(parameter int N = 8);
  logic [2:0] mode;
  logic [1:0] ready_def;
  logic trig_lvl;
  logic trig_rise;
  logic [N-1:0] en;
  logic [N-1:0] fault;
  logic [N-1:0] need_ref;
  logic [N-1:0] need_load;
  logic [N-1:0] busy;
  logic [N-1:0] empty;
  logic [N-1:0] start;
  logic [N-1:0] run;
  logic [N-1:0] ready;
  modport ctl (output mode, ready_def, trig_lvl, trig_rise, en, fault, need_ref, need_load, busy, empty,
    input start, run, ready);
  modport gate (input mode, ready_def, trig_lvl, trig_rise, en, fault, need_ref, need_load, busy, empty,
    output start, run, ready);
endinterface : chan_bus_if

// ---- in_sync.sv ----
// Two-stage synchroniser with rising-edge detect for isolated inputs
`timescale 1ns/1ns
module in_sync #(parameter int W = 1) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Asynchronous levels
  input wire logic [W-1:0] d,
  // Synchronised level and edge
  output logic [W-1:0] q,
  output logic [W-1:0] rise
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } sync_t;

  sync_t st_reg;
  sync_t st_next;

  always_comb begin
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.s2;
  assign rise = st_reg.s2 & ~st_reg.s3;
endmodule : in_sync

// ---- chan_gate.sv ----
// Per-channel trigger eligibility, dispense start, meter run and ready state
`timescale 1ns/1ns
`include "plc_io_params.svh"
module chan_gate #(parameter int N = 8) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Channel bundle
  chan_bus_if.gate cb
);
  typedef struct packed {
    logic [N-1:0] start;
    logic [N-1:0] run;
    logic [N-1:0] ready;
  } gate_t;

  gate_t st_reg;
  gate_t st_next;
  logic [N-1:0] elig;

  always_comb begin
    elig = cb.en & ~cb.fault & ~cb.need_ref & ~cb.need_load;
    st_next.start = '0;
    st_next.run = '0;
    // Prime, bubble and setup modes fall through with nothing started
    case (cb.mode)
      `MODE_DISPENSE: begin
        if (cb.trig_rise) begin
          st_next.start = elig;
        end
      end
      `MODE_METER: begin
        if (cb.trig_lvl) begin
          st_next.run = elig & ~cb.empty;
        end
      end
      default: begin
        st_next.start = '0;
      end
    endcase
    case (cb.ready_def)
      `RDEF_IDLE: st_next.ready = ~cb.busy;
      `RDEF_IDLE_NOFAULT: st_next.ready = ~cb.busy & ~cb.fault;
      `RDEF_ARMED: st_next.ready = ~cb.busy & elig;
      default: st_next.ready = ~cb.busy & elig & ~cb.empty;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign cb.start = st_reg.start;
  assign cb.run = st_reg.run;
  assign cb.ready = st_reg.ready;
endmodule : chan_gate

// ---- plc_system_io.sv ----
// System PLC discrete interface: trigger, load, ready, fault and load-required logic
`timescale 1ns/1ns
`include "plc_io_params.svh"

// Register map, one 32-bit word per offset, unused upper bits read as zero
// 0x00 control
//   mode in bits 2:0
//   ready definition in bits 5:4
// 0x04 channel enable, one bit per channel
//   writes are masked by the lockout switches
//   enabling a locked channel raises the lockout warning event
//   a select switch edge toggles the enable of an unlocked channel
// 0x08 status, read only
//   bit 0 synchronised trigger level
//   bit 1 synchronised load level
//   bit 2 system ready
//   bit 3 no channel faulted
//   bit 4 load required
//   bit 5 load sequence busy
// 0x0c event status, write one to clear, a new event wins over its clear
//   bit 0 dispense start issued
//   bit 1 load start issued
//   bit 2 lockout warning
//   bit 3 new channel fault
// 0x10 event mask, same layout, irq follows the unmasked events
// 0x14 channel status, read only: synchronised lockout switches
// 0x18 dispense volume in pump steps
// 0x1c rate in pump steps per second
// Other offsets ignore writes and read as zero

// Mode codes
//   0 setup, 1 prime, 2 dispense, 3 meter, 4 bubble clear
//   codes 5 to 7 act as setup: nothing is triggered
// Ready definitions
//   0 channel idle
//   1 channel idle and not faulted
//   2 channel idle and eligible for a trigger
//   3 as 2, with the chamber not empty

// Timing
//   two synchroniser edges, one edge-detect stage, then one output register
//   ch_start, ch_run and load_start follow a pin change by three clock edges
//   fault and load required follow the channel status by one cycle
//   ch_ready_conduct by one cycle, system ready by two
//   read data stand only in the cycle after the read strobe

// Limitation
//   a load edge that arrives while a load is armed or running is lost, not queued

// Summary of operation
// - The system trigger has no effect while the mode is prime or bubble clear.
// - In dispense mode each eligible channel gets one start pulse on the trigger's rising edge only.
// - Disabled, faulted, reference-needing or load-needing channels are skipped; the rest trigger.
// - In meter mode eligible channels run while the trigger stays applied, stopping on release or empty chamber.
// - System ready is true only when every channel is ready.
// - The meaning of ready for system and channel outputs comes from a software-written setting.
// - The fault output is inverted: true with no channel faulted, false once any channel faults.
// - A rising edge on the load input starts a load cycle; the input is ignored until loading ends.
// - Load required is true while any enabled channel needs a load or is loading.
// - Each isolated output conducts when its logical signal is true, after the fault inversion.
// - No parameter survives power loss; everything resets to zero and must be reprogrammed.
// - Volumes are step counts and rates are steps per second.
// - A lockout switch forces a channel disabled and refuses software enables with a warning.
module plc_system_io #(parameter int N = 8) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Interrupt
  output logic irq,
  // Isolated PLC inputs
  input wire logic trig_in,
  input wire logic load_in,
  // Front panel enable switch per channel
  input wire logic [N-1:0] lockout_in,
  input wire logic [N-1:0] select_in,
  // Channel status
  input wire logic [N-1:0] ch_fault,
  input wire logic [N-1:0] ch_need_ref,
  input wire logic [N-1:0] ch_need_load,
  input wire logic [N-1:0] ch_loading,
  input wire logic [N-1:0] ch_busy,
  input wire logic [N-1:0] ch_empty,
  // Channel commands
  output logic [N-1:0] ch_enabled,
  output logic [N-1:0] ch_start,
  output logic [N-1:0] ch_run,
  output logic [N-1:0] ch_ready_conduct,
  output logic load_start,
  output logic [31:0] volume_steps,
  output logic [31:0] rate_sps,
  // Isolated outputs
  output logic ready_conduct,
  output logic fault_conduct,
  output logic load_conduct
);
  typedef struct packed {
    logic [2:0] mode;
    logic [1:0] ready_def;
    logic [N-1:0] en;
    logic [31:0] volume;
    logic [31:0] rate;
    logic [`IRQ_W-1:0] stat;
    logic [`IRQ_W-1:0] mask;
    logic irq;
    logic [31:0] rdata;
    logic ready;
    logic fault_n;
    logic load_out;
    logic load_start;
    plc_io_pkg::load_state_t lst;
    logic [N-1:0] fault_d;
  } state_t;

  state_t st_reg;
  state_t st_next;

  logic [2*N+1:0] sync_q;
  logic [2*N+1:0] sync_rise;
  logic trig_q;
  logic trig_rise;
  logic load_q;
  logic load_rise;
  logic [N-1:0] lock_q;
  logic [N-1:0] sel_rise;

  chan_bus_if #(.N(N)) cb ();

  // All isolated inputs through one synchroniser bank
  in_sync #(.W(2 * N + 2)) u_sync (
    .clock(clock),
    .nrst(nrst),
    .d({select_in, lockout_in, load_in, trig_in}),
    .q(sync_q),
    .rise(sync_rise)
  );

  assign trig_q = sync_q[0];
  assign trig_rise = sync_rise[0];
  assign load_q = sync_q[1];
  assign load_rise = sync_rise[1];
  assign lock_q = sync_q[N+1:2];
  assign sel_rise = sync_rise[2*N+1:N+2];

  assign cb.mode = st_reg.mode;
  assign cb.ready_def = st_reg.ready_def;
  assign cb.trig_lvl = trig_q;
  assign cb.trig_rise = trig_rise;
  assign cb.en = st_reg.en;
  assign cb.fault = ch_fault;
  assign cb.need_ref = ch_need_ref;
  assign cb.need_load = ch_need_load;
  assign cb.busy = ch_busy;
  assign cb.empty = ch_empty;

  chan_gate #(.N(N)) u_gate (
    .clock(clock),
    .nrst(nrst),
    .cb(cb)
  );

  always_comb begin
    logic [`IRQ_W-1:0] set;
    logic [`IRQ_W-1:0] clr;
    logic [N-1:0] en_w;
    set = '0;
    clr = '0;
    en_w = st_reg.en;
    st_next = st_reg;

    // Software writes; parameters only arrive over the command link
    if (wr) begin
      case (addr)
        `OFS_CTRL: begin
          st_next.mode = wdata[`CTRL_MODE_LSB +: `CTRL_MODE_W];
          st_next.ready_def = wdata[`CTRL_RDEF_LSB +: `CTRL_RDEF_W];
        end
        `OFS_CHAN_EN: begin
          en_w = wdata[N-1:0];
          if (|(wdata[N-1:0] & lock_q & ~st_reg.en)) begin
            set[`IRQ_LOCKOUT] = 1'b1;
          end
        end
        `OFS_IRQ_STAT: begin
          clr = wdata[`IRQ_W-1:0];
        end
        `OFS_IRQ_MASK: begin
          st_next.mask = wdata[`IRQ_W-1:0];
        end
        `OFS_VOLUME: begin
          st_next.volume = wdata;
        end
        `OFS_RATE: begin
          st_next.rate = wdata;
        end
        default: begin
          clr = '0;
        end
      endcase
    end

    // Select switch toggles enable; lockout forces disable
    en_w = en_w ^ (sel_rise & ~lock_q);
    if (|(sel_rise & lock_q & ~st_reg.en)) begin
      set[`IRQ_LOCKOUT] = 1'b1;
    end
    st_next.en = en_w & ~lock_q;

    // Load cycle sequencer
    st_next.load_start = 1'b0;
    case (st_reg.lst)
      plc_io_pkg::LOAD_IDLE: begin
        if (load_rise) begin
          st_next.load_start = 1'b1;
          st_next.lst = plc_io_pkg::LOAD_ARM;
          set[`IRQ_LOAD] = 1'b1;
        end
      end
      plc_io_pkg::LOAD_ARM: begin
        st_next.lst = plc_io_pkg::LOAD_RUN;
      end
      plc_io_pkg::LOAD_RUN: begin
        if (!(|ch_loading)) begin
          st_next.lst = plc_io_pkg::LOAD_IDLE;
        end
      end
      default: begin
        st_next.lst = plc_io_pkg::LOAD_IDLE;
      end
    endcase

    // System outputs
    st_next.ready = &cb.ready;
    st_next.fault_n = ~(|ch_fault);
    st_next.load_out = |(st_reg.en & (ch_need_load | ch_loading));
    st_next.fault_d = ch_fault;

    // Events
    if (|cb.start) begin
      set[`IRQ_TRIG] = 1'b1;
    end
    if (|(ch_fault & ~st_reg.fault_d)) begin
      set[`IRQ_FAULT] = 1'b1;
    end
    st_next.stat = (st_reg.stat & ~clr) | set;
    st_next.irq = |(st_next.stat & st_next.mask);

    // Read data valid only in the cycle after the strobe
    st_next.rdata = '0;
    if (rd) begin
      case (addr)
        `OFS_CTRL: begin
          st_next.rdata[`CTRL_MODE_LSB +: `CTRL_MODE_W] = st_reg.mode;
          st_next.rdata[`CTRL_RDEF_LSB +: `CTRL_RDEF_W] = st_reg.ready_def;
        end
        `OFS_CHAN_EN: st_next.rdata[N-1:0] = st_reg.en;
        `OFS_STATUS: begin
          st_next.rdata[5:0] = {st_reg.lst != plc_io_pkg::LOAD_IDLE, st_reg.load_out,
            st_reg.fault_n, st_reg.ready, load_q, trig_q};
        end
        `OFS_IRQ_STAT: st_next.rdata[`IRQ_W-1:0] = st_reg.stat;
        `OFS_IRQ_MASK: st_next.rdata[`IRQ_W-1:0] = st_reg.mask;
        `OFS_CHAN_STAT: st_next.rdata[N-1:0] = lock_q;
        `OFS_VOLUME: st_next.rdata = st_reg.volume;
        `OFS_RATE: st_next.rdata = st_reg.rate;
        default: st_next.rdata = '0;
      endcase
    end
  end

  // Everything clears at reset, nothing is retained
  always_ff @(posedge clock) begin
    if (!nrst) begin
      st_reg <= '0;
      st_reg.lst <= plc_io_pkg::LOAD_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // Conduction equals logical truth
  assign ready_conduct = st_reg.ready;
  assign fault_conduct = st_reg.fault_n;
  assign load_conduct = st_reg.load_out;
  assign ch_ready_conduct = cb.ready;
  assign ch_start = cb.start;
  assign ch_run = cb.run;
  assign ch_enabled = st_reg.en;
  assign load_start = st_reg.load_start;
  assign volume_steps = st_reg.volume;
  assign rate_sps = st_reg.rate;
  assign rdata = st_reg.rdata;
  assign irq = st_reg.irq;
endmodule : plc_system_io

// ---- plc_partner.sv ----
// Customer controller model driving the trigger and load lines
`timescale 1ns/1ns
module plc_partner (
  // Clock
  input wire logic clock,
  // Discrete lines, high = applied
  output logic trig_in,
  output logic load_in
);
  initial begin
    trig_in = 1'b0;
    load_in = 1'b0;
  end
  // Lines only trigger, never configure
  task automatic drive(input logic t, input logic l, input int hold);
    @(posedge clock);
    trig_in <= t;
    load_in <= l;
    repeat (hold) @(posedge clock);
  endtask : drive
endmodule : plc_partner

// ---- plc_system_io_sva.sv ----
// Port assertions for the system I/O block
`timescale 1ns/1ns
module plc_system_io_sva #(parameter int N = 8) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Inputs
  input wire logic load_in,
  input wire logic trig_in,
  input wire logic [N-1:0] ch_fault,
  input wire logic [N-1:0] ch_need_load,
  input wire logic [N-1:0] ch_loading,
  input wire logic [N-1:0] ch_empty,
  // Outputs
  input wire logic [N-1:0] ch_start,
  input wire logic [N-1:0] ch_run,
  input wire logic [N-1:0] ch_ready_conduct,
  input wire logic load_start,
  input wire logic ready_conduct,
  input wire logic fault_conduct,
  input wire logic load_conduct
);
  logic [3:0] low_reg;
  // Saturating count of released trigger cycles
  always_ff @(posedge clock) begin
    if (!nrst || trig_in) begin
      low_reg <= 4'h0;
    end else if (low_reg != 4'hf) begin
      low_reg <= low_reg + 4'h1;
    end
  end
  default clocking dc @(posedge clock); endclocking
  default disable iff (!nrst);
  a_fault_inverted:
    assert property ($past(nrst) |-> fault_conduct == !$past(|ch_fault)) else $error("fault drive wrong");
  a_load_idle:
    assert property ($past(nrst) && $past(~|(ch_need_load | ch_loading)) |-> !load_conduct) else $error("load stuck");
  a_ready_and:
    assert property ($past(nrst) |-> ready_conduct == $past(&ch_ready_conduct)) else $error("ready not and");
  a_start_pulse:
    assert property (|ch_start |=> ~|ch_start) else $error("start too long");
  a_run_empty:
    assert property ((ch_run & $past(ch_empty)) == '0) else $error("empty runs");
  a_run_release:
    assert property (low_reg > 4'h5 |-> ~|ch_run) else $error("run unheld");
  a_load_once:
    assert property (load_start |=> !load_start [*2]) else $error("load repeats");
  a_load_cause:
    assert property (load_start |-> $past(load_in, 2)) else $error("load uncaused");
endmodule : plc_system_io_sva

bind plc_system_io plc_system_io_sva #(.N(N)) plc_system_io_sva_i (.clock(clock), .nrst(nrst), .load_in(load_in),
  .trig_in(trig_in), .ch_fault(ch_fault), .ch_need_load(ch_need_load), .ch_loading(ch_loading), .ch_empty(ch_empty),
  .ch_start(ch_start), .ch_run(ch_run), .ch_ready_conduct(ch_ready_conduct), .load_start(load_start),
  .ready_conduct(ready_conduct), .fault_conduct(fault_conduct), .load_conduct(load_conduct));

// ---- plc_system_io_bench.sv ----
// Self-checking bench for the system I/O block
`timescale 1ns/1ns
`include "plc_io_params.svh"
module plc_system_io_bench;
  logic clock = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0;
  logic irq, load_start, ready_conduct, fault_conduct, load_conduct, trig_in, load_in;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, volume_steps, rate_sps;
  logic [7:0] lockout_in = 8'h00, select_in = 8'h00, ch_fault = 8'h00, ch_need_ref = 8'h00;
  logic [7:0] ch_need_load = 8'h00, ch_loading = 8'h00, ch_busy = 8'h00, ch_empty = 8'h00;
  logic [7:0] ch_enabled, ch_start, ch_run, ch_ready_conduct;
  int err_total = 0;
  int samples_checked = 0;
  always #2 clock = ~clock;
  plc_system_io plc_system_io_i (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .trig_in(trig_in), .load_in(load_in), .lockout_in(lockout_in), .select_in(select_in),
    .ch_fault(ch_fault), .ch_need_ref(ch_need_ref), .ch_need_load(ch_need_load), .ch_loading(ch_loading),
    .ch_busy(ch_busy), .ch_empty(ch_empty), .ch_enabled(ch_enabled), .ch_start(ch_start), .ch_run(ch_run),
    .ch_ready_conduct(ch_ready_conduct), .load_start(load_start), .volume_steps(volume_steps), .rate_sps(rate_sps),
    .ready_conduct(ready_conduct), .fault_conduct(fault_conduct), .load_conduct(load_conduct));
  plc_partner plc_partner_i (.clock(clock), .trig_in(trig_in), .load_in(load_in));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_n(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : wait_n
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask : rd_chk
  task automatic t_reset;
    for (int i = 0; i < 9; i++) if (i != 2 && i != 5) rd_chk(8'(i * 4), 32'h0);
    chk(fault_conduct, 32'h1);
    rd_chk(`OFS_STATUS, 32'h0000_000c);
    wr_reg(`OFS_VOLUME, 32'h0001_e240);
    wr_reg(`OFS_RATE, 32'h0000_03e8);
    wait_n(1);
    chk(volume_steps, 32'h0001_e240);
    chk(rate_sps, 32'h0000_03e8);
    rd_chk(`OFS_VOLUME, 32'h0001_e240);
    rd_chk(`OFS_RATE, 32'h0000_03e8);
  endtask : t_reset
  task automatic t_modes;
    logic [31:0] st, rn, n;
    wr_reg(`OFS_CHAN_EN, 32'hff);
    for (int m = 0; m < 5; m++) begin
      wr_reg(`OFS_CTRL, 32'(m));
      st = 0;
      n = 0;
      plc_partner_i.drive(1'b1, 1'b0, 0);
      repeat (10) begin
        wait_n(1);
        st |= 32'(ch_start);
        n += 32'($countones(ch_start));
      end
      rn = 32'(ch_run);
      plc_partner_i.drive(1'b0, 1'b0, 8);
      chk(st, m == `MODE_DISPENSE ? 32'hff : 32'h0);
      chk(n, m == `MODE_DISPENSE ? 32'h8 : 32'h0);
      chk(rn, m == `MODE_METER ? 32'hff : 32'h0);
    end
  endtask : t_modes
  task automatic t_elig;
    logic [31:0] st;
    st = 0;
    ch_fault <= 8'h02;
    ch_need_ref <= 8'h04;
    ch_need_load <= 8'h08;
    wr_reg(`OFS_CHAN_EN, 32'hef);
    wr_reg(`OFS_CTRL, 32'(`MODE_DISPENSE));
    wait_n(1);
    chk(fault_conduct, 32'h0);
    chk(load_conduct, 32'h1);
    plc_partner_i.drive(1'b1, 1'b0, 0);
    repeat (10) begin
      wait_n(1);
      st |= 32'(ch_start);
    end
    chk(st, 32'he1);
    plc_partner_i.drive(1'b0, 1'b0, 6);
    ch_need_load <= 8'h10;
    wait_n(2);
    chk(load_conduct, 32'h0);
    @(posedge clock);
    ch_fault <= 8'h00;
    ch_need_ref <= 8'h00;
    ch_need_load <= 8'h00;
  endtask : t_elig
  task automatic t_meter;
    wr_reg(`OFS_CHAN_EN, 32'hff);
    wr_reg(`OFS_CTRL, 32'(`MODE_METER));
    plc_partner_i.drive(1'b1, 1'b0, 6);
    #1 chk(ch_run, 32'hff);
    @(posedge clock);
    ch_empty <= 8'h01;
    wait_n(2);
    chk(ch_run, 32'hfe);
    plc_partner_i.drive(1'b0, 1'b0, 6);
    #1 chk(ch_run, 32'h0);
    @(posedge clock);
    ch_empty <= 8'h00;
  endtask : t_meter
  task automatic t_ready;
    ch_fault <= 8'h02;
    for (int d = 0; d < 4; d++) begin
      wr_reg(`OFS_CTRL, 32'(d << `CTRL_RDEF_LSB));
      wait_n(2);
      chk(ch_ready_conduct, d == 0 ? 32'hff : 32'hfd);
      chk(ready_conduct, 32'(d == 0));
    end
    wr_reg(`OFS_CTRL, 32'h0);
    ch_busy <= 8'h80;
    ch_fault <= 8'h00;
    wait_n(2);
    chk(ch_ready_conduct, 32'h7f);
    chk(ready_conduct, 32'h0);
    @(posedge clock);
    ch_busy <= 8'h00;
  endtask : t_ready
  task automatic t_load;
    logic [31:0] n;
    n = 0;
    wr_reg(`OFS_IRQ_STAT, 32'hf);
    wr_reg(`OFS_IRQ_MASK, 32'h0);
    plc_partner_i.drive(1'b0, 1'b1, 0);
    for (int i = 0; i < 20; i++) begin
      if (i == 8 || i == 10) plc_partner_i.drive(1'b0, i == 10, 0);
      wait_n(1);
      n += 32'(load_start);
      if (load_start) begin
        @(posedge clock);
        ch_loading <= 8'hff;
      end
    end
    chk(load_conduct, 32'h1);
    chk(irq, 32'h0);
    wr_reg(`OFS_IRQ_MASK, 32'h2);
    wait_n(1);
    chk(irq, 32'h1);
    @(posedge clock);
    ch_loading <= 8'h00;
    wait_n(8);
    chk(n, 32'h1);
    chk(load_conduct, 32'h0);
    rd_chk(`OFS_IRQ_STAT, 32'h2);
    wr_reg(`OFS_IRQ_STAT, 32'h2);
    wait_n(1);
    chk(irq, 32'h0);
    plc_partner_i.drive(1'b0, 1'b0, 4);
  endtask : t_load
  task automatic t_lockout;
    wr_reg(`OFS_IRQ_STAT, 32'hf);
    lockout_in <= 8'h01;
    wait_n(4);
    wr_reg(`OFS_CHAN_EN, 32'hff);
    wait_n(1);
    chk(ch_enabled, 32'hfe);
    rd_chk(`OFS_IRQ_STAT, 32'h4);
    rd_chk(`OFS_CHAN_STAT, 32'h1);
    @(posedge clock);
    select_in <= 8'h80;
    wait_n(4);
    @(posedge clock);
    select_in <= 8'h00;
    wait_n(2);
    chk(ch_enabled, 32'h7e);
    @(posedge clock);
    lockout_in <= 8'h00;
  endtask : t_lockout
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    report_and_stop;
  end
  initial begin
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    t_reset;
    $display("reset test ended");
    t_modes;
    $display("mode test ended");
    t_elig;
    $display("eligibility test ended");
    t_meter;
    $display("meter test ended");
    t_ready;
    $display("ready test ended");
    t_load;
    $display("load test ended");
    t_lockout;
    $display("lockout test ended");
    report_and_stop;
  end
endmodule : plc_system_io_bench
